//--- mtw_formatter.sv
// formats converted channel samples into the multiplexed input image
//
// Chosen here: the plain strobed port and the address map.
import mtw_pkg::*;

// How it works
// - present one block of thirty-two input points
// - low sixteen points carry straight binary reading
// - two-bit code names channel, upper bit first
// - one shared data field, code tracks channel
// - one open-sensor flag per channel, upper word
// - sign-magnitude: bit fifteen set means negative
// - optional two's complement format for negatives
// - temperatures arrive already in tenths degree
// - unipolar ranges use full sixteen-bit code
// - bipolar ranges give 15-bit magnitude plus sign
// - sign-magnitude bipolar polarity only in sign bit
module mtw_formatter
	import mtw_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        sys_rst_i,
	input  wire mtw_sample_t sample_i,
	input  wire logic        sample_valid_i,
	input  wire mtw_range_t  range_i,
	input  wire logic [3:0]  open_sensor_i,
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic [31:0]      reg_rdata_o,
	output mtw_image_t       image_o,
	output logic             image_strobe_o,
	output logic             irq_o
);

	logic [7:0]  ctrl_r;
	logic [7:0]  status_r;
	logic [7:0]  irq_en_r;
	logic [3:0]  open_r;
	logic [15:0] data_nxt;
	logic [7:0]  evt_set;
	logic        publish;

	// bipolar magnitude saturates at the 15-bit ceiling
	function automatic logic [14:0] mtw_clip15(input logic [15:0] m);
		mtw_clip15 = (m[15]) ? MTW_BIP_MAX : m[14:0];
	endfunction

	// negate for two's complement; zero stays zero so no minus zero
	function automatic logic [15:0] mtw_neg16(input logic [14:0] m);
		mtw_neg16 = 16'h0000 - {1'b0, m};
	endfunction

	assign publish = sample_valid_i & ctrl_r[MTW_CTRL_ENABLE];

	// data field encoder for range and number format
	always_comb begin
		data_nxt = sample_i.mag;
		if (range_i != MTW_UNIPOLAR) begin
			if (!sample_i.neg) begin
				data_nxt = {1'b0, mtw_clip15(sample_i.mag)};
			end else if (ctrl_r[MTW_CTRL_TWOS]) begin
				data_nxt = mtw_neg16(mtw_clip15(sample_i.mag));
			end else begin
				data_nxt = {1'b1, mtw_clip15(sample_i.mag)};
			end
		end
	end

	// one register load keeps value, sign and code coherent; the host may
	// sample any cycle, so splitting these would expose torn words
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			image_o.data      <= 16'h0000;
			image_o.chan_code <= 2'h0;
		end else if (publish) begin
			image_o.data      <= data_nxt;
			image_o.chan_code <= sample_i.chan;
		end
	end

	// open flags follow the sensors every cycle, independent of the mux
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			image_o.open_flags <= 4'h0;
			image_o.resv_mid   <= 6'h00;
			image_o.resv_hi    <= 4'h0;
			open_r             <= 4'h0;
		end else begin
			image_o.open_flags <= open_sensor_i;
			open_r             <= open_sensor_i;
		end
	end

	// new-word pulse for any consumer of the image
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			image_strobe_o <= 1'b0;
		end else begin
			image_strobe_o <= publish;
		end
	end

	assign evt_set = {open_sensor_i & ~open_r, 3'h0, publish};

	// control and interrupt enable registers
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_r   <= MTW_CTRL_RST;
			irq_en_r <= 8'h00;
		end else if (reg_wr_i) begin
			if (reg_addr_i == MTW_REG_CTRL) begin
				ctrl_r <= reg_wdata_i[7:0];
			end else if (reg_addr_i == MTW_REG_IRQ_EN) begin
				irq_en_r <= reg_wdata_i[7:0];
			end
		end
	end

	// sticky status; a new event wins over a clear in the same cycle
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			status_r <= 8'h00;
		end else if (reg_wr_i && reg_addr_i == MTW_REG_IRQ_CLR) begin
			status_r <= (status_r & ~reg_wdata_i[7:0]) | evt_set;
		end else begin
			status_r <= status_r | evt_set;
		end
	end

	// level interrupt from enabled sticky bits
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |((status_r | evt_set) & irq_en_r);
		end
	end

	// read data stands one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (reg_rd_i) begin
			if (reg_addr_i == MTW_REG_CTRL) begin
				reg_rdata_o <= {24'h000000, ctrl_r};
			end else if (reg_addr_i == MTW_REG_STATUS) begin
				reg_rdata_o <= {24'h000000, status_r};
			end else if (reg_addr_i == MTW_REG_IRQ_EN) begin
				reg_rdata_o <= {24'h000000, irq_en_r};
			end else if (reg_addr_i == MTW_REG_IMAGE) begin
				reg_rdata_o <= image_o;
			end else begin
				reg_rdata_o <= 32'h0000_0000;
			end
		end else begin
			reg_rdata_o <= 32'h0000_0000;
		end
	end

	// checks on the published image; word and code move as one
	word_load_a: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		publish |=> image_o.chan_code == $past(sample_i.chan)
			&& image_strobe_o
	) else $error("channel code not loaded with word");

	word_hold_a: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		!publish |=> $stable(image_o.data) && $stable(image_o.chan_code)
	) else $error("data field changed without a sample");

	strobe_only_a: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		!publish |=> !image_strobe_o
	) else $error("strobe without an accepted sample");

	// a disabled formatter must not let a stray valid through
	off_ignore_a: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		sample_valid_i && !ctrl_r[MTW_CTRL_ENABLE] |=> !image_strobe_o
	) else $error("sample published while disabled");

	resv_zero_a: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		image_o.resv_mid == 6'h00 && image_o.resv_hi == 4'h0
	) else $error("reserved image points not zero");

	// number format checks, at least one per encoding branch
	sign_mag_a: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		publish && range_i != MTW_UNIPOLAR && !ctrl_r[MTW_CTRL_TWOS]
		|=> image_o.data[MTW_SIGN_POS] == $past(sample_i.neg)
	) else $error("sign bit does not match polarity");

	// both polarities share one magnitude space
	bip_mag_a: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		publish && range_i != MTW_UNIPOLAR && !ctrl_r[MTW_CTRL_TWOS]
		|=> image_o.data[14:0] == mtw_clip15($past(sample_i.mag))
	) else $error("bipolar magnitude altered");

	twos_fmt_a: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		publish && range_i != MTW_UNIPOLAR && ctrl_r[MTW_CTRL_TWOS]
		&& sample_i.neg |=> image_o.data + {1'b0, mtw_clip15(
		$past(sample_i.mag))} == 16'h0000
	) else $error("two's complement word wrong");

	// a negative zero must not turn into the most negative code
	neg_zero_a: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		publish && range_i != MTW_UNIPOLAR && ctrl_r[MTW_CTRL_TWOS]
		&& sample_i.neg && sample_i.mag == 16'h0000
		|=> image_o.data == 16'h0000
	) else $error("negative zero not zero");

	unipolar_a: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		publish && range_i == MTW_UNIPOLAR
		|=> image_o.data == $past(sample_i.mag)
	) else $error("unipolar code altered");

	bip_pos_a: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		publish && range_i != MTW_UNIPOLAR && !sample_i.neg
		|=> image_o.data <= {1'b0, MTW_BIP_MAX}
	) else $error("positive bipolar exceeds 15 bits");

	// tenths arrive ready made, so in-range values pass unscaled
	temp_tenths_a: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		publish && range_i == MTW_TEMPERATURE && !sample_i.neg
		&& !sample_i.mag[15] |=> image_o.data == $past(sample_i.mag)
	) else $error("temperature reading rescaled");

	// open-sensor flags and their sticky events
	open_flag_a: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		##1 image_o.open_flags == $past(open_sensor_i)
	) else $error("open flag does not follow sensor");

	open_evt_a: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		|(open_sensor_i & ~open_r) |=> (status_r[MTW_EVT_OPEN +: 4]
		& $past(open_sensor_i & ~open_r)) == $past(open_sensor_i & ~open_r)
	) else $error("open event not recorded");

	// register side: sticky bits, interrupt and read data timing
	status_keep_a: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		!(reg_wr_i && reg_addr_i == MTW_REG_IRQ_CLR)
		|=> (status_r & $past(status_r)) == $past(status_r)
	) else $error("status bit lost without a clear");

	clr_drop_a: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == MTW_REG_IRQ_CLR
		&& (reg_wdata_i[7:0] & evt_set) == 8'h00
		|=> (status_r & $past(reg_wdata_i[7:0])) == 8'h00
	) else $error("cleared status bit still set");

	irq_off_a: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		((status_r | evt_set) & irq_en_r) == 8'h00 |=> !irq_o
	) else $error("interrupt with nothing enabled pending");

	rd_zero_a: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		!reg_rd_i |=> reg_rdata_o == 32'h0000_0000
	) else $error("read data outside its cycle");

	img_read_a: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		reg_rd_i && reg_addr_i == MTW_REG_IMAGE
		|=> reg_rdata_o == $past(image_o)
	) else $error("image read differs from image");

	rd_status_a: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		reg_rd_i && reg_addr_i == MTW_REG_STATUS
		|=> reg_rdata_o == {24'h000000, $past(status_r)}
	) else $error("status read differs from status");

	unmapped_rd_a: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		reg_rd_i && reg_addr_i > MTW_REG_IMAGE
		|=> reg_rdata_o == 32'h0000_0000
	) else $error("unmapped read not zero");

	// main scenarios worth seeing at least once
	cov_ch4_c: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		publish && sample_i.chan == 2'h3);
	cov_neg_c: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		publish && sample_i.neg && ctrl_r[MTW_CTRL_TWOS]);
	cov_open_c: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		|(open_sensor_i & ~open_r) ##1 irq_o);
	// event and clear in one cycle: the set must win
	cov_clr_set_c: cover property (@(posedge clock_i)
		disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == MTW_REG_IRQ_CLR && publish);
	cov_uni_c: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		publish && range_i == MTW_UNIPOLAR);

endmodule

//--- mtw_pkg.sv
// shared constants and carriers for the multiplexed temperature input word
package mtw_pkg;

	localparam int MTW_NUM_CH       = 4;
	localparam int MTW_DATA_W       = 16;
	localparam int MTW_IMAGE_W      = 32;
	localparam int MTW_SIGN_POS     = 15;
	localparam int MTW_CODE_LO_POS  = 16;
	localparam int MTW_CODE_HI_POS  = 17;
	localparam int MTW_OPEN_POS     = 24;
	localparam logic [15:0] MTW_UNI_MAX  = 16'hffff;
	localparam logic [14:0] MTW_BIP_MAX  = 15'h7fff;
	localparam logic [31:0] MTW_IMAGE_RST = 32'h0000_0000;

	// register map of the plain register port
	localparam logic [3:0] MTW_REG_CTRL   = 4'h0;
	localparam logic [3:0] MTW_REG_STATUS = 4'h1;
	localparam logic [3:0] MTW_REG_IRQ_EN = 4'h2;
	localparam logic [3:0] MTW_REG_IRQ_CLR = 4'h3;
	localparam logic [3:0] MTW_REG_IMAGE  = 4'h4;
	localparam logic [3:0] MTW_REG_EVT    = 4'h5;

	// control bit positions and reset value
	localparam int MTW_CTRL_TWOS    = 0;
	localparam int MTW_CTRL_ENABLE  = 1;
	localparam logic [7:0] MTW_CTRL_RST = 8'h02;

	// event bits: 0 word published, 4..7 sensor opened on ch1..ch4
	localparam int MTW_EVT_WORD     = 0;
	localparam int MTW_EVT_OPEN     = 4;

	typedef enum logic [1:0] {
		MTW_UNIPOLAR,
		MTW_BIPOLAR,
		MTW_TEMPERATURE
	} mtw_range_t;

	// one converted sample handed in by the converter
	typedef struct packed {
		logic [1:0]  chan;
		logic        neg;
		logic [15:0] mag;
	} mtw_sample_t;

	// the 32-point discrete input image seen by the host
	typedef struct packed {
		logic [3:0]  resv_hi;
		logic [3:0]  open_flags;
		logic [5:0]  resv_mid;
		logic [1:0]  chan_code;
		logic [15:0] data;
	} mtw_image_t;

endpackage

//--- mtw_host_model.sv
// host side model: routes each published word by its channel code
module mtw_host_model
	import mtw_pkg::*;
(
	input  wire logic             clock_i,
	input  wire mtw_image_t       image_i,
	input  wire logic             strobe_i,
	output logic [3:0][15:0]      chan_val_o,
	output logic [3:0]            chan_neg_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// masking bit 15 keeps sign-magnitude negatives from reading as huge values
	always_ff @(posedge clock_i) begin
		if (strobe_i) begin
			chan_val_o[image_i.chan_code] <= image_i.data & 16'h7fff;
			chan_neg_o[image_i.chan_code] <= image_i.data[15];
		end
	end
endmodule

//--- mtw_formatter_test.sv
// self-checking bench of the multiplexed input word formatter
module mtw_formatter_test
	import mtw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic             clock_i;
	logic             sys_rst_i;
	mtw_sample_t      smp;
	logic             smp_valid;
	mtw_range_t       range_sel;
	logic [3:0]       open_sens;
	logic [3:0]       reg_addr;
	logic [31:0]      reg_wdata;
	logic             reg_wr;
	logic             reg_rd;
	logic [31:0]      reg_rdata;
	mtw_image_t       image;
	logic             image_strobe;
	logic             irq;
	logic [3:0][15:0] host_val;
	logic [3:0]       host_neg;
	int               err_count;
	int               samples_checked;
	int               cycles;

	mtw_formatter i_mtw_formatter (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.sample_i(smp), .sample_valid_i(smp_valid), .range_i(range_sel),
		.open_sensor_i(open_sens), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_rdata_o(reg_rdata), .image_o(image),
		.image_strobe_o(image_strobe), .irq_o(irq));

	mtw_host_model i_mtw_host_model (.clock_i(clock_i), .image_i(image),
		.strobe_i(image_strobe), .chan_val_o(host_val),
		.chan_neg_o(host_neg));

	// free-running clock, 10 ns period
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	task automatic print_verdict();
		if (err_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// hang guard, far above the roughly sixty cycles needed
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 2000) begin
			err_count++;
			print_verdict();
		end
	end

	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", what, e, g);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock_i);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock_i);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clock_i);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock_i);
		reg_rd <= 1'b0;
		#1;
		chk("rdata", e, reg_rdata);
	endtask

	// publish one sample, then check strobe, code and data together
	task automatic pub(input logic [1:0] ch, input logic ng,
		input logic [15:0] m, input mtw_range_t rg, input logic [17:0] e);
		@(posedge clock_i);
		range_sel <= rg;
		smp <= '{chan: ch, neg: ng, mag: m};
		smp_valid <= 1'b1;
		@(posedge clock_i);
		smp_valid <= 1'b0;
		#1;
		chk("strobe", 32'h1, {31'h0, image_strobe});
		chk("image", {14'h0, e}, {14'h0, image.chan_code, image.data});
	endtask

	initial begin
		{smp, smp_valid, open_sens, reg_addr, reg_wdata} = '0;
		{reg_wr, reg_rd, err_count, samples_checked, cycles} = '0;
		range_sel = MTW_BIPOLAR;
		sys_rst_i = 1'b1;
		repeat (6) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		#1;
		chk("image", 32'h0, image);
		rd(MTW_REG_CTRL, 32'h2);
		rd(4'hf, 32'h0);
		wr(MTW_REG_IRQ_EN, 32'h1);
		for (int k = 0; k < 4; k++) begin
			pub(k[1:0], 1'b1, 16'h5 + k[15:0], MTW_BIPOLAR,
				{k[1:0], 16'h8005 + k[15:0]});
		end
		@(posedge clock_i);
		#1;
		for (int k = 0; k < 4; k++) begin
			chk("host", {16'h0, 16'h5 + k[15:0]}, {16'h0, host_val[k]});
		end
		chk("host_neg", 32'hf, {28'h0, host_neg});
		chk("irq", 32'h1, {31'h0, irq});
		rd(MTW_REG_STATUS, 32'h1);
		pub(2'd0, 1'b0, 16'hffff, MTW_UNIPOLAR, {2'd0, 16'hffff});
		pub(2'd1, 1'b0, 16'hffff, MTW_BIPOLAR, {2'd1, 16'h7fff});
		pub(2'd2, 1'b1, 16'h7fff, MTW_BIPOLAR, {2'd2, 16'hffff});
		pub(2'd3, 1'b0, 16'd8482, MTW_TEMPERATURE, {2'd3, 16'd8482});
		wr(MTW_REG_CTRL, 32'h3);
		pub(2'd0, 1'b1, 16'h2, MTW_TEMPERATURE, {2'd0, 16'hfffe});
		@(posedge clock_i);
		open_sens <= 4'ha;
		repeat (2) @(posedge clock_i);
		#1;
		chk("open", 32'ha, {28'h0, image.open_flags});
		rd(MTW_REG_STATUS, 32'ha1);
		// open events are masked, so clearing the word bit drops irq
		wr(MTW_REG_IRQ_CLR, 32'h1);
		repeat (2) @(posedge clock_i);
		#1;
		chk("irq", 32'h0, {31'h0, irq});
		wr(MTW_REG_IRQ_EN, 32'hf0);
		repeat (2) @(posedge clock_i);
		#1;
		chk("irq", 32'h1, {31'h0, irq});
		wr(MTW_REG_IRQ_CLR, 32'hf0);
		repeat (2) @(posedge clock_i);
		#1;
		chk("irq", 32'h0, {31'h0, irq});
		rd(MTW_REG_STATUS, 32'h0);
		// clear and new word in one cycle: the set wins
		@(posedge clock_i);
		reg_wr <= 1'b1;
		reg_addr <= MTW_REG_IRQ_CLR;
		reg_wdata <= 32'h1;
		smp_valid <= 1'b1;
		@(posedge clock_i);
		reg_wr <= 1'b0;
		smp_valid <= 1'b0;
		rd(MTW_REG_STATUS, 32'h1);
		// disabled: a valid pulse must not publish
		wr(MTW_REG_CTRL, 32'h0);
		@(posedge clock_i);
		smp_valid <= 1'b1;
		@(posedge clock_i);
		smp_valid <= 1'b0;
		#1;
		chk("strobe", 32'h0, {31'h0, image_strobe});
		print_verdict();
	end
endmodule
